// ==== t16_timer.sv ====
// t16_timer: 16-bit timer/counter with capture, two compare channels and flags
// assumes an 8-bit register port driven on ref_clk, strobes one cycle long
//
// Contract
// RULE1 - filter on: capture source changes after four equal samples
// RULE2 - edge select 0 triggers on falling, 1 on rising edge
// RULE3 - capture copies counter into capture value and sets capture flag
// RULE4 - capture value used as TOP disconnects the capture input
// RULE5 - capture value as TOP: capture flag set when counter reaches TOP
// RULE6 - comparator output may replace the capture pin as trigger
// RULE7 - software writes zero to reserved bit 5 of capture/clock control
// RULE8 - clock select: stop, /1, /8, /64, /256, /1024, ext fall, ext rise
// RULE9 - external pin edges clock the counter even if pin is output
// RULE10 - force bit in non-PWM modes applies an immediate compare action
// RULE11 - forced compare raises no interrupt and never clears the counter
// RULE12 - forced compare does not set the compare flag
// RULE13 - force bits always read as zero
// RULE14 - software keeps force bits zero when writing in PWM modes
// RULE15 - 16-bit registers accessed through one shared high-byte temp
// RULE16 - counter write blocks compare match on the next timer tick
// RULE17 - each compare value compared continuously with the counter
// RULE18 - irq requested when enable, global enable and flag are set
// RULE19 - compare flag set in the tick after counter equals compare
// RULE20 - flags clear on vector acknowledge or write of one
// RULE21 - overflow flag at MAX in normal/CLEAR_ON_MATCH_MODE, per mode table otherwise
// RULE22 - four-bit waveform mode picks sequence, TOP, update and overflow
// RULE23 - writing zero to a flag bit leaves it unchanged
module t16_timer
  import t16_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic ext_clock_pin,
  input wire logic glob_irq_en,
  input wire logic [3:0] irq_ack,
  output logic [3:0] irq_req,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_oe_a,
  output logic wave_oe_b
);
  typedef struct packed {
    logic [7:0] wctl;
    logic [7:0] cctl;
    logic [7:0] ien;
    logic [7:0] flags;
    logic [7:0] temp;
    logic [15:0] cnt;
    logic [15:0] ocra;
    logic [15:0] ocrb;
    logic [15:0] ocra_buf;
    logic [15:0] ocrb_buf;
    logic [15:0] icr;
    logic down;
    logic blk;
    logic cap_prev;
    logic wa;
    logic wb;
    logic oea;
    logic oeb;
    logic [3:0] irq;
    logic [7:0] rdata;
  } t16_state_s;
  t16_state_s s_ff, nxt_s;

  t16_clk_if clk ();
  logic cap_lvl;
  logic [3:0] wgm;
  logic [15:0] top;
  logic fast, phase, nonpwm, icr_top, tk;
  logic at_top, at_bot, upd, mat_a, mat_b, fa, fb, cap_evt, edge_hit;
  logic [7:0] set, clr;

  // capture source mux ahead of the filter so both sources are filtered [RULE6]
  t16_cap_filter u_filt (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(s_ff.cctl[B_FILT]),
    .din(s_ff.wctl[B_CSRC] ? comparator_out : capture_pin),
    .dout(cap_lvl)
  );

  t16_clk_sel u_csel (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ext_clock_pin(ext_clock_pin),
    .clk(clk.sel)
  );

  assign clk.clock_select = s_ff.cctl[2:0];
  assign tk = clk.tick;

  // next output level of one compare channel
  function automatic logic wave_next(input logic [1:0] com, input logic cur,
                                     input logic hit, input logic bot, input logic dn,
                                     input logic is_fast, input logic is_nonpwm,
                                     input logic tog_ok);
    logic v;
    v = cur;
    if (hit) begin
      if (com == 2'h1 && (is_nonpwm || tog_ok)) begin
        v = !cur;
      end else if (com == 2'h2) begin
        v = is_fast || is_nonpwm ? 1'b0 : dn;
      end else if (com == 2'h3) begin
        v = is_fast || is_nonpwm ? 1'b1 : !dn;
      end
    end
    // fast mode sets or clears at BOTTOM, winning over a match at TOP
    if (bot && is_fast && com[1]) begin
      v = !com[0];
    end
    return v;
  endfunction

  always_comb begin
    nxt_s = s_ff;
    set = 8'h00;
    clr = 8'h00;
    upd = 1'b0;
    nxt_s.rdata = 8'h00;
    wgm = {s_ff.cctl[4:3], s_ff.wctl[1:0]};
    top = mode_top(wgm, s_ff.ocra, s_ff.icr); // [RULE22]
    fast = mode_fast(wgm);
    phase = mode_phase(wgm);
    nonpwm = !fast && !phase;
    icr_top = mode_icr_top(wgm);
    at_top = s_ff.cnt == top;
    at_bot = s_ff.cnt == RST_WORD;
    // continuous compare, dropped on the tick after a counter write [RULE17] [RULE16]
    mat_a = tk && !s_ff.blk && s_ff.cnt == s_ff.ocra;
    mat_b = tk && !s_ff.blk && s_ff.cnt == s_ff.ocrb;
    // forced compare only in non-PWM modes [RULE10]
    fa = wr_en && addr == A_FORCE && wr_data[B_FA] && nonpwm;
    fb = wr_en && addr == A_FORCE && wr_data[B_FB] && nonpwm;

    // counting sequence per waveform mode [RULE22]
    if (tk) begin
      nxt_s.blk = 1'b0;
      if (phase) begin
        if (!s_ff.down && at_top) begin
          nxt_s.down = 1'b1;
          nxt_s.cnt = s_ff.cnt - 16'h0001;
        end else if (s_ff.down && at_bot) begin
          nxt_s.down = 1'b0;
          nxt_s.cnt = s_ff.cnt + 16'h0001;
          set[B_OVF] = 1'b1; // [RULE21]
        end else begin
          nxt_s.cnt = s_ff.down ? s_ff.cnt - 16'h0001 : s_ff.cnt + 16'h0001;
        end
        upd = wgm inside {4'h8, 4'h9} ? (s_ff.down && at_bot) : (!s_ff.down && at_top);
      end else begin
        // only a real match at TOP clears: forced strobes never reach here [RULE11]
        nxt_s.cnt = at_top ? RST_WORD : s_ff.cnt + 16'h0001;
        nxt_s.down = 1'b0;
        if (fast ? at_top : s_ff.cnt == WORD_MAX) begin
          set[B_OVF] = 1'b1; // [RULE21]
        end
        upd = fast ? at_top : 1'b1;
      end
      if (icr_top && at_top) begin
        set[B_CAP] = 1'b1; // [RULE5]
      end
      set[B_CMPA] = mat_a; // [RULE19]
      set[B_CMPB] = mat_b; // [RULE19]
    end
    // double-buffered compare values load at the mode's update point
    if (upd) begin
      nxt_s.ocra = s_ff.ocra_buf;
      nxt_s.ocrb = s_ff.ocrb_buf;
    end

    // waveform outputs; forced strobes act like a match but set no flag [RULE10] [RULE12]
    nxt_s.wa = wave_next(s_ff.wctl[7:6], s_ff.wa, mat_a || fa, tk && at_top, s_ff.down,
                         fast, nonpwm, wgm inside {4'h9, 4'hb, 4'he, 4'hf});
    nxt_s.wb = wave_next(s_ff.wctl[5:4], s_ff.wb, mat_b || fb, tk && at_top, s_ff.down,
                         fast, nonpwm, 1'b0);
    nxt_s.oea = s_ff.wctl[7:6] != 2'h0;
    nxt_s.oeb = s_ff.wctl[5:4] != 2'h0 && (nonpwm || s_ff.wctl[5]);

    // capture: selected edge, ignored while capture value is TOP [RULE2] [RULE4]
    nxt_s.cap_prev = cap_lvl;
    edge_hit = s_ff.cctl[B_EDGE] ? (cap_lvl && !s_ff.cap_prev) : (!cap_lvl && s_ff.cap_prev);
    cap_evt = edge_hit && !icr_top;
    if (cap_evt) begin
      nxt_s.icr = s_ff.cnt; // [RULE3]
      set[B_CAP] = 1'b1;
    end

    // register writes; low byte commits {temp, low} as one word [RULE15]
    if (wr_en) begin
      case (addr)
        A_IRQ_EN: nxt_s.ien = wr_data & IRQ_MASK;
        A_IRQ_FLAGS: clr = wr_data & IRQ_MASK; // [RULE20] [RULE23]
        A_WAVE_CTL: nxt_s.wctl = wr_data & WCTL_MASK;
        A_CAP_CLK: nxt_s.cctl = wr_data & CCTL_MASK; // [RULE7]
        A_CNT_H, A_CAP_H, A_CMPA_H, A_CMPB_H: nxt_s.temp = wr_data;
        A_CNT_L: begin
          nxt_s.cnt = {s_ff.temp, wr_data};
          nxt_s.blk = 1'b1; // [RULE16]
        end
        A_CAP_L: nxt_s.icr = {s_ff.temp, wr_data};
        A_CMPA_L: begin
          nxt_s.ocra_buf = {s_ff.temp, wr_data};
          if (nonpwm) begin
            nxt_s.ocra = {s_ff.temp, wr_data};
          end
        end
        A_CMPB_L: begin
          nxt_s.ocrb_buf = {s_ff.temp, wr_data};
          if (nonpwm) begin
            nxt_s.ocrb = {s_ff.temp, wr_data};
          end
        end
        default: ;
      endcase
    end

    // reads; low byte of counter/capture latches the high byte in temp [RULE15]
    if (rd_en) begin
      case (addr)
        A_IRQ_EN: nxt_s.rdata = s_ff.ien;
        A_IRQ_FLAGS: nxt_s.rdata = s_ff.flags;
        A_WAVE_CTL: nxt_s.rdata = s_ff.wctl;
        A_CAP_CLK: nxt_s.rdata = s_ff.cctl;
        A_FORCE: nxt_s.rdata = 8'h00; // [RULE13]
        A_CNT_L: begin
          nxt_s.rdata = s_ff.cnt[7:0];
          nxt_s.temp = s_ff.cnt[15:8];
        end
        A_CAP_L: begin
          nxt_s.rdata = s_ff.icr[7:0];
          nxt_s.temp = s_ff.icr[15:8];
        end
        A_CNT_H, A_CAP_H: nxt_s.rdata = s_ff.temp;
        A_CMPA_L: nxt_s.rdata = s_ff.ocra_buf[7:0];
        A_CMPA_H: nxt_s.rdata = s_ff.ocra_buf[15:8];
        A_CMPB_L: nxt_s.rdata = s_ff.ocrb_buf[7:0];
        A_CMPB_H: nxt_s.rdata = s_ff.ocrb_buf[15:8];
        default: nxt_s.rdata = 8'h00;
      endcase
    end

    // acknowledge or write-one clears; a same-cycle set wins [RULE20]
    clr = clr | {2'h0, irq_ack[3], 2'h0, irq_ack[2], irq_ack[1], irq_ack[0]};
    nxt_s.flags = (s_ff.flags & ~clr) | set;
    // requests follow flags gated by enables and the global enable [RULE18]
    nxt_s.irq = {4{glob_irq_en}} &
                {s_ff.ien[B_CAP] & s_ff.flags[B_CAP], s_ff.ien[B_CMPB] & s_ff.flags[B_CMPB],
                 s_ff.ien[B_CMPA] & s_ff.flags[B_CMPA], s_ff.ien[B_OVF] & s_ff.flags[B_OVF]};
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rd_data = s_ff.rdata;
  assign irq_req = s_ff.irq;
  assign wave_out_a = s_ff.wa;
  assign wave_out_b = s_ff.wb;
  assign wave_oe_a = s_ff.oea;
  assign wave_oe_b = s_ff.oeb;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_cap_copy;
    cap_evt |=> s_ff.icr == $past(s_ff.cnt) && s_ff.flags[B_CAP];
  endproperty
  a_cap_copy: assert property (p_cap_copy) else $error("capture not taken"); // [RULE3]

  property p_cap_off;
    (icr_top && !tk && !(wr_en && addr == A_CAP_L)) |=> s_ff.icr == $past(s_ff.icr);
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("capture while icr is top"); // [RULE4]

  property p_force_flag;
    (wr_en && addr == A_FORCE && !tk && !s_ff.flags[B_CMPA]) |=> !s_ff.flags[B_CMPA];
  endproperty
  a_force_flag: assert property (p_force_flag) else $error("force set a flag"); // [RULE12]

  property p_force_rd;
    (rd_en && addr == A_FORCE) |=> rd_data == 8'h00;
  endproperty
  a_force_rd: assert property (p_force_rd) else $error("force bits read nonzero"); // [RULE13]

  property p_block;
    (wr_en && addr == A_CNT_L) ##1 tk |=> !s_ff.flags[B_CMPA] || $past(s_ff.flags[B_CMPA]);
  endproperty
  a_block: assert property (p_block) else $error("match after counter write"); // [RULE16]

  property p_ocf;
    mat_a |=> s_ff.flags[B_CMPA];
  endproperty
  a_ocf: assert property (p_ocf) else $error("compare flag missing"); // [RULE19]

  property p_w0;
    (wr_en && addr == A_IRQ_FLAGS && !wr_data[B_OVF] && irq_ack == 4'h0
     && s_ff.flags[B_OVF]) |=> s_ff.flags[B_OVF];
  endproperty
  a_w0: assert property (p_w0) else $error("zero write cleared flag"); // [RULE23]

  property p_w1c;
    (wr_en && addr == A_IRQ_FLAGS && wr_data[B_CMPB] && !mat_b) |=> !s_ff.flags[B_CMPB];
  endproperty
  a_w1c: assert property (p_w1c) else $error("one write did not clear"); // [RULE20]

  property p_irq;
    (glob_irq_en && s_ff.ien[B_CAP] && s_ff.flags[B_CAP]) |=> irq_req[3];
  endproperty
  a_irq: assert property (p_irq) else $error("capture irq missing"); // [RULE18]

  property p_tmp;
    (rd_en && addr == A_CNT_L) ##1 !(rd_en || wr_en) ##1 (rd_en && addr == A_CNT_H)
      |=> rd_data == $past(s_ff.cnt[15:8], 3);
  endproperty
  a_tmp: assert property (p_tmp) else $error("high byte not from temp"); // [RULE15]

  c_cap: cover property (cap_evt);
  c_ocf: cover property (mat_a ##1 s_ff.flags[B_CMPA]);
  c_ovf: cover property (tk && $rose(s_ff.flags[B_OVF]));
endmodule

// ==== t16_pkg.sv ====
// t16_pkg: register map, field positions, reset values and timing counts
// assumes an 8-bit register port and one 250 MHz clock
package t16_pkg;
  // register byte addresses
  localparam logic [7:0] A_IRQ_FLAGS = 8'h36;
  localparam logic [7:0] A_IRQ_EN = 8'h6f;
  localparam logic [7:0] A_WAVE_CTL = 8'h80;
  localparam logic [7:0] A_CAP_CLK = 8'h81;
  localparam logic [7:0] A_FORCE = 8'h82;
  localparam logic [7:0] A_CNT_L = 8'h84;
  localparam logic [7:0] A_CNT_H = 8'h85;
  localparam logic [7:0] A_CAP_L = 8'h86;
  localparam logic [7:0] A_CAP_H = 8'h87;
  localparam logic [7:0] A_CMPA_L = 8'h88;
  localparam logic [7:0] A_CMPA_H = 8'h89;
  localparam logic [7:0] A_CMPB_L = 8'h8a;
  localparam logic [7:0] A_CMPB_H = 8'h8b;
  // reset values and writable-bit masks
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] WORD_MAX = 16'hffff;
  localparam logic [7:0] IRQ_MASK = 8'h27;
  localparam logic [7:0] CCTL_MASK = 8'hdf;
  localparam logic [7:0] WCTL_MASK = 8'hfb;
  // field positions
  localparam int B_CAP = 5;
  localparam int B_CMPB = 2;
  localparam int B_CMPA = 1;
  localparam int B_OVF = 0;
  localparam int B_FILT = 7;
  localparam int B_EDGE = 6;
  localparam int B_CSRC = 3;
  localparam int B_FA = 7;
  localparam int B_FB = 6;
  // clock select codes and prescaler taps
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_W = 10;
  localparam logic [9:0] TAP8 = 10'h007;
  localparam logic [9:0] TAP64 = 10'h03f;
  localparam logic [9:0] TAP256 = 10'h0ff;
  localparam logic [9:0] TAP1024 = 10'h3ff;
  localparam int FILT_SAMPLES = 4;

  function automatic logic mode_fast(input logic [3:0] m);
    return m inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
  endfunction
  function automatic logic mode_phase(input logic [3:0] m);
    return m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
  endfunction
  function automatic logic mode_icr_top(input logic [3:0] m);
    return m inside {4'h8, 4'ha, 4'hc, 4'he};
  endfunction
  function automatic logic [15:0] mode_top(input logic [3:0] m, input logic [15:0] ocra,
                                           input logic [15:0] icr);
    case (m)
      4'h1, 4'h5: mode_top = 16'h00ff;
      4'h2, 4'h6: mode_top = 16'h01ff;
      4'h3, 4'h7: mode_top = 16'h03ff;
      4'h4, 4'h9, 4'hb, 4'hf: mode_top = ocra;
      4'h8, 4'ha, 4'hc, 4'he: mode_top = icr;
      default: mode_top = 16'hffff;
    endcase
  endfunction
endpackage

// ==== t16_clk_if.sv ====
// t16_clk_if: clock select code out of the core, count enable back in
// assumes both ends run on ref_clk
interface t16_clk_if;
  logic [2:0] clock_select;
  logic tick;
  modport core (output clock_select, input tick);
  modport sel (input clock_select, output tick);
endinterface

// ==== t16_cap_filter.sv ====
// t16_cap_filter: majority-free run-length filter on the capture source
// assumes the input is already synchronous to ref_clk
module t16_cap_filter
  import t16_pkg::*;
#(
  parameter int SAMPLES = FILT_SAMPLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic [2:0] run;
    logic out;
  } t16_filt_s;
  t16_filt_s s_ff, nxt_s;

  // output follows only after SAMPLES equal differing samples [RULE1]
  always_comb begin
    nxt_s = s_ff;
    if (!en) begin
      nxt_s.out = din;
      nxt_s.run = 3'h0;
    end else if (din == s_ff.out) begin
      nxt_s.run = 3'h0;
    end else if (s_ff.run == 3'(SAMPLES - 1)) begin
      nxt_s.out = din;
      nxt_s.run = 3'h0;
    end else begin
      nxt_s.run = s_ff.run + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign dout = s_ff.out;

  property p_filt_run;
    @(posedge ref_clk) disable iff (!rst_n)
    (en && $past(en) && s_ff.out != $past(s_ff.out)) |->
      ($past(din) == s_ff.out && $past(din, 2) == s_ff.out
       && $past(din, 3) == s_ff.out && $past(din, 4) == s_ff.out);
  endproperty
  a_filt_run: assert property (p_filt_run) else $error("filter changed early"); // [RULE1]
endmodule

// ==== t16_clk_sel.sv ====
// t16_clk_sel: free-running prescaler and external clock edge detector
// assumes ext_clock_pin is synchronous and slower than half of ref_clk
module t16_clk_sel
  import t16_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ext_clock_pin,
  t16_clk_if.sel clk
);
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic ext_prev;
    logic tick;
  } t16_csel_s;
  t16_csel_s s_ff, nxt_s;

  // prescaler never resets on a select change, so first count may jitter
  always_comb begin
    nxt_s = s_ff;
    nxt_s.pre = s_ff.pre + 10'h001;
    nxt_s.ext_prev = ext_clock_pin;
    case (clk.clock_select) // [RULE8]
      CS_DIV1: nxt_s.tick = 1'b1;
      CS_DIV8: nxt_s.tick = (s_ff.pre & TAP8) == TAP8;
      CS_DIV64: nxt_s.tick = (s_ff.pre & TAP64) == TAP64;
      CS_DIV256: nxt_s.tick = (s_ff.pre & TAP256) == TAP256;
      CS_DIV1024: nxt_s.tick = s_ff.pre == TAP1024;
      // pin edges count regardless of its port direction [RULE9]
      CS_EXT_FALL: nxt_s.tick = s_ff.ext_prev && !ext_clock_pin;
      CS_EXT_RISE: nxt_s.tick = !s_ff.ext_prev && ext_clock_pin;
      default: nxt_s.tick = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign clk.tick = s_ff.tick;

  property p_stop;
    @(posedge ref_clk) disable iff (!rst_n)
    (clk.clock_select == CS_STOP) [*2] |-> !clk.tick;
  endproperty
  a_stop: assert property (p_stop) else $error("tick while stopped"); // [RULE8]
endmodule

// ==== t16_cpu_model.sv ====
// t16_cpu_model: cpu core stand-in driving the byte-wide register port
// assumes the slave never waits and read data stand one cycle after the strobe
module t16_cpu_model
  import t16_pkg::*;
(
  input wire logic ref_clk,
  output logic [7:0] addr,
  output logic [7:0] wr_data,
  output logic wr_en,
  output logic rd_en,
  input wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial begin
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  // one-cycle write; reserved control bit is always sent as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= (a == A_CAP_CLK) ? (d & CCTL_MASK) : d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    wr_data <= ~d; // stale data must not look valid
  endtask

  // one-cycle read; data taken in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1 d = rd_data;
  endtask

  // high byte parks in the shared temp, low byte commits the word
  task automatic wr16(input logic [7:0] a_lo, input logic [15:0] d);
    wr(a_lo + 8'h01, d[15:8]);
    wr(a_lo, d[7:0]);
  endtask

  // low byte read first so the high byte comes from the same instant
  task automatic rd16(input logic [7:0] a_lo, output logic [15:0] d);
    rd(a_lo, d[7:0]);
    rd(a_lo + 8'h01, d[15:8]);
  endtask
endmodule

// ==== test_timer16_capture_compare_regs.sv ====
// test_timer16_capture_compare_regs: register-level checks of the 16-bit timer
// assumes t16_cpu_model drives the register port; pins are driven here
module test_timer16_capture_compare_regs
  import t16_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC_MAX = 20000;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr, wr_data, rd_data, d;
  logic wr_en, rd_en, wave_out_a, wave_out_b, wave_oe_a, wave_oe_b, o;
  logic capture_pin = 1'b0;
  logic comparator_out = 1'b0;
  logic ext_clock_pin = 1'b0;
  logic glob_irq_en = 1'b0;
  logic [3:0] irq_ack = 4'h0;
  logic [3:0] irq_req;
  logic [15:0] w;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int dv[5] = '{1, 8, 64, 256, 1024};

  // 250 MHz reference
  always #2 ref_clk = ~ref_clk;

  t16_timer DUT (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .capture_pin(capture_pin),
    .comparator_out(comparator_out), .ext_clock_pin(ext_clock_pin),
    .glob_irq_en(glob_irq_en), .irq_ack(irq_ack), .irq_req(irq_req),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .wave_oe_a(wave_oe_a),
    .wave_oe_b(wave_oe_b));

  t16_cpu_model cpu (.ref_clk(ref_clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data));

  task automatic end_sim();
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", s, exp, got);
    end
  endtask

  task automatic chk_rng(input string s, input int lo, input int hi, input logic [15:0] got);
    total_checks++;
    if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
      err_total++;
      $display("wrong value %s expected %0d to %0d seen %h", s, lo, hi, got);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                      input string s);
    cpu.rd(a, d);
    chk(s, {8'h00, e}, {8'h00, d & m});
  endtask

  task automatic r16chk(input logic [7:0] a, input logic [15:0] e, input string s);
    cpu.rd16(a, w);
    chk(s, e, w);
  endtask

  // irq_req trails its flag by a cycle, so look two edges on
  task automatic irq_chk(input logic [3:0] e);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq_req", {12'h000, e}, {12'h000, irq_req});
    @(posedge ref_clk);
  endtask

  // run the counter with a control value for n cycles, then stop it
  task automatic run(input logic [7:0] c, input int n);
    cpu.wr(A_CAP_CLK, c);
    repeat (n) @(posedge ref_clk);
    cpu.wr(A_CAP_CLK, c & 8'hf8);
  endtask

  // level on one capture source, long enough to pass the filter
  task automatic src(input logic use_cmp, input logic v);
    @(posedge ref_clk);
    {comparator_out, capture_pin} <= use_cmp ? {v, capture_pin} : {comparator_out, v};
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic cap_chk(input logic [7:0] flg, input logic [15:0] val);
    rchk(A_IRQ_FLAGS, 8'h20, flg, "capture flag");
    if (flg != 8'h00) begin
      r16chk(A_CAP_L, val, "capture value");
      cpu.wr(A_IRQ_FLAGS, 8'h20);
    end
  endtask

  // hang guard: a run past the ceiling is a failure
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, writable bits, strobes, unmapped place
    rchk(A_IRQ_EN, 8'hff, RST_REG, "irq_en");
    rchk(A_CAP_CLK, 8'hff, RST_REG, "cap_clk");
    rchk(A_IRQ_FLAGS, 8'hff, RST_REG, "flags");
    r16chk(A_CNT_L, RST_WORD, "counter");
    cpu.wr(A_IRQ_EN, 8'hff);
    rchk(A_IRQ_EN, 8'hff, IRQ_MASK, "irq_en");
    cpu.wr(A_IRQ_EN, 8'h00);
    cpu.wr(A_FORCE, 8'hc0);
    rchk(A_FORCE, 8'hff, 8'h00, "force");
    cpu.wr(8'hff, 8'h5a);
    rchk(8'hff, 8'hff, 8'h00, "unmapped");
    // temp shared: a compare high byte lands in the counter
    cpu.wr16(A_CNT_L, 16'h1234);
    r16chk(A_CNT_L, 16'h1234, "counter");
    cpu.wr(A_CMPA_H, 8'h56);
    cpu.wr(A_CNT_L, 8'h78);
    r16chk(A_CNT_L, 16'h5678, "counter");
    // compare B at zero is blocked by the counter write
    cpu.wr16(A_CMPA_L, 16'h0005);
    cpu.wr16(A_CMPB_L, RST_WORD);
    cpu.wr16(A_CNT_L, RST_WORD);
    run({5'h00, CS_DIV1}, 40);
    rchk(A_IRQ_FLAGS, 8'hff, 8'h02, "flags");
    cpu.wr(A_IRQ_EN, 8'h02);
    glob_irq_en <= 1'b1;
    irq_chk(4'h2);
    cpu.wr(A_IRQ_FLAGS, 8'h00);
    rchk(A_IRQ_FLAGS, 8'hff, 8'h02, "flags");
    @(posedge ref_clk);
    irq_ack <= 4'h2;
    @(posedge ref_clk);
    irq_ack <= 4'h0;
    rchk(A_IRQ_FLAGS, 8'hff, 8'h00, "flags");
    irq_chk(4'h0);
    // counter written onto compare A while running: that match is dropped
    cpu.wr(A_CAP_CLK, {5'h00, CS_DIV1});
    cpu.wr16(A_CNT_L, 16'h0005);
    cpu.wr(A_CAP_CLK, 8'h00);
    rchk(A_IRQ_FLAGS, 8'h02, 8'h00, "blocked match");
    // overflow with the global enable off
    glob_irq_en <= 1'b0;
    cpu.wr(A_IRQ_EN, 8'h01);
    cpu.wr16(A_CNT_L, 16'hfff0);
    run({5'h00, CS_DIV1}, 40);
    rchk(A_IRQ_FLAGS, 8'h01, 8'h01, "overflow");
    irq_chk(4'h0);
    cpu.wr(A_IRQ_FLAGS, 8'h27);
    rchk(A_IRQ_FLAGS, 8'hff, 8'h00, "flags");
    // stopped, then every prescaler tap over a fixed window
    cpu.wr16(A_CNT_L, 16'h0042);
    run({5'h00, CS_STOP}, 100);
    r16chk(A_CNT_L, 16'h0042, "count");
    for (int i = 0; i < 5; i++) begin
      cpu.wr16(A_CNT_L, RST_WORD);
      run(8'(i + 1), 2048);
      cpu.rd16(A_CNT_L, w);
      chk_rng("count", 2050 / dv[i] - 2, 2050 / dv[i] + 2, w);
    end
    // external pin, falling then rising edges
    for (int c = 6; c < 8; c++) begin
      cpu.wr16(A_CNT_L, RST_WORD);
      cpu.wr(A_CAP_CLK, 8'(c));
      repeat (5) begin
        repeat (4) @(posedge ref_clk);
        ext_clock_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ext_clock_pin <= 1'b0;
      end
      repeat (6) @(posedge ref_clk);
      cpu.wr(A_CAP_CLK, 8'h00);
      r16chk(A_CNT_L, 16'h0005, "ext count");
    end
    // capture edges with the counter held still
    cpu.wr16(A_CNT_L, 16'h0abc);
    cpu.wr(A_CAP_CLK, 8'h40);
    src(1'b0, 1'b1);
    cap_chk(8'h20, 16'h0abc);
    cpu.wr16(A_CNT_L, 16'h0def);
    src(1'b0, 1'b0);
    cap_chk(8'h00, 16'h0000);
    cpu.wr(A_CAP_CLK, 8'h00);
    src(1'b0, 1'b1);
    cap_chk(8'h00, 16'h0000);
    src(1'b0, 1'b0);
    cap_chk(8'h20, 16'h0def);
    // filter: a three-sample glitch is dropped
    cpu.wr(A_CAP_CLK, 8'hc0);
    capture_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    capture_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    cap_chk(8'h00, 16'h0000);
    src(1'b0, 1'b1);
    cap_chk(8'h20, 16'h0def);
    src(1'b0, 1'b0);
    // comparator as source, pin ignored
    cpu.wr(A_WAVE_CTL, 8'h08);
    cpu.wr(A_CAP_CLK, 8'h40);
    cpu.wr16(A_CNT_L, 16'h0111);
    src(1'b0, 1'b1);
    cap_chk(8'h00, 16'h0000);
    src(1'b0, 1'b0);
    src(1'b1, 1'b1);
    cap_chk(8'h20, 16'h0111);
    src(1'b1, 1'b0);
    cpu.wr(A_WAVE_CTL, 8'h00);
    // capture value as TOP: pin cut off, flag at TOP
    cpu.wr(A_CAP_CLK, 8'h18);
    cpu.wr16(A_CAP_L, 16'h0020);
    cpu.wr16(A_CNT_L, RST_WORD);
    src(1'b0, 1'b1);
    cap_chk(8'h00, 16'h0000);
    src(1'b0, 1'b0);
    run(8'h19, 60);
    cpu.wr(A_IRQ_EN, 8'h20);
    glob_irq_en <= 1'b1;
    irq_chk(4'h8);
    cap_chk(8'h20, 16'h0020);
    // forced compare, non-pwm only so force bits stay legal
    cpu.wr(A_IRQ_FLAGS, 8'h27);
    cpu.wr(A_CAP_CLK, 8'h08);
    cpu.wr(A_WAVE_CTL, 8'h70);
    cpu.wr16(A_CMPA_L, 16'h0100);
    cpu.wr16(A_CNT_L, 16'h0050);
    glob_irq_en <= 1'b1;
    cpu.wr(A_IRQ_EN, 8'h02);
    #1 o = wave_out_a;
    cpu.wr(A_FORCE, 8'hc0);
    repeat (2) @(posedge ref_clk);
    #1 chk("wave_a", {15'h0000, ~o}, {15'h0000, wave_out_a});
    chk("wave_oe_a", 16'h0001, {15'h0000, wave_oe_a});
    chk("wave_b", 16'h0001, {15'h0000, wave_out_b});
    chk("wave_oe_b", 16'h0001, {15'h0000, wave_oe_b});
    chk("irq_req", 16'h0000, {12'h000, irq_req});
    rchk(A_IRQ_FLAGS, 8'h06, 8'h00, "compare flags");
    r16chk(A_CNT_L, 16'h0050, "counter");
    end_sim();
  end
endmodule
